// >>> hw/sgcs_consts.vh
// constants for the scatter-gather cycle sequencer
// Function
// [RULE1] Memory mode: first request runs four primary copies, then an alternate cycle.
// [RULE2] Alternate copy and task phases until basic task or invalid structure.
// [RULE3] After all N primary transfers, primary cycle type becomes invalid.
// [RULE4] Completion pulse only when transaction ends with a basic cycle.
// [RULE5] Software sets increments and sizes of primary word to word.
// [RULE6] Software sets primary arbitration interval to four transfers.
// [RULE7] Primary cycle type selects memory or peripheral scatter-gather sequencing.
// [RULE8] Software clears burst-after-alternate bit for memory scatter-gather.
// [RULE9] Peripheral mode: burst bit one sets burst-only flag after alternate cycle.
// [RULE10] Bus protection from destination field on writes, source field on reads.
// [RULE11] Software sets primary count to N minus one, N multiple of four.
// [RULE12] Memory mode: auto-request and arbitrate after each copy and each task.
// [RULE13] Memory transaction starts on request line or software request.
// [RULE14] Peripheral mode: alternate cycle follows copy at once, active held high.
// [RULE15] Peripheral mode: next copy needs a fresh peripheral request and top priority.
// [RULE16] Software places four-word descriptors at primary source, then enables channel.
// [RULE17] Task copied after primary invalidation runs as a basic cycle.
// [RULE18] Final basic task ends with one-cycle completion pulse, then arbitration.
// [RULE19] Task codes: 101 memory alternate, 111 peripheral alternate, 001 basic.
// [RULE20] On completing any cycle its structure's cycle type becomes invalid.
`ifndef SGCS_CONSTS_VH
`define SGCS_CONSTS_VH

// register byte offsets
`define SGCS_OFF_CTRL     8'h00
`define SGCS_OFF_PRI_SRC  8'h04
`define SGCS_OFF_PRI_DST  8'h08
`define SGCS_OFF_PRI_CFG  8'h0C
`define SGCS_OFF_ALT_BASE 8'h10
`define SGCS_OFF_STATUS   8'h14
`define SGCS_OFF_ALT_W0   8'h18
`define SGCS_OFF_ALT_W1   8'h1C
`define SGCS_OFF_ALT_W2   8'h20

// control register bits
`define SGCS_CTRL_EN    0
`define SGCS_CTRL_SWREQ 1
`define SGCS_CTRL_BURST 2

// control word fields
`define SGCS_CC_HI    2
`define SGCS_CC_LO    0
`define SGCS_NXBURST  3
`define SGCS_NM1_HI   13
`define SGCS_NM1_LO   4
`define SGCS_RPOW_HI  17
`define SGCS_RPOW_LO  14
`define SGCS_SPROT_HI 20
`define SGCS_SPROT_LO 18
`define SGCS_DPROT_HI 23
`define SGCS_DPROT_LO 21

// cycle type codes
`define SGCS_CC_INVALID  3'h0
`define SGCS_CC_BASIC    3'h1
`define SGCS_CC_MEM_PRI  3'h4
`define SGCS_CC_MEM_ALT  3'h5
`define SGCS_CC_PER_PRI  3'h6
`define SGCS_CC_PER_ALT  3'h7

// index of the last word in a descriptor copy
`define SGCS_COPY_LAST 2'h3

// reset values
`define SGCS_RST_WORD 32'h0000_0000

`endif

// >>> hw/sgcs_sync2.v
// two-stage synchroniser for an asynchronous level input
module sgcs_sync2 (
   // clock and reset
   input  wire clock,
   input  wire resetn,
   // level in and out
   input  wire din,
   output reg  dout
);

   reg meta_r;

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         meta_r <= 1'b0;
         dout   <= 1'b0;
      end else begin
         meta_r <= din;
         dout   <= meta_r;
      end
   end

endmodule

// >>> hw/sgcs_xfer.v
// one word transfer: read source, then write destination
`include "sgcs_consts.vh"
module sgcs_xfer (
   // clock and reset
   input  wire        clock,
   input  wire        resetn,
   // command from the sequencer
   input  wire        start,
   input  wire [31:0] srcAddr,
   input  wire [31:0] dstAddr,
   input  wire [2:0]  srcProt,
   input  wire [2:0]  dstProt,
   output reg         done,
   output reg  [31:0] data,
   // memory master port
   output reg         memReq,
   output reg         memWrite,
   output reg  [31:0] memAddr,
   output reg  [31:0] memWdata,
   output reg  [2:0]  memProt,
   input  wire        memAck,
   input  wire [31:0] memRdata
);

   reg [31:0] dstAddr_r;
   reg [2:0]  dstProt_r;

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         done      <= 1'b0;
         data      <= `SGCS_RST_WORD;
         memReq    <= 1'b0;
         memWrite  <= 1'b0;
         memAddr   <= `SGCS_RST_WORD;
         memWdata  <= `SGCS_RST_WORD;
         memProt   <= 3'h0;
         dstAddr_r <= `SGCS_RST_WORD;
         dstProt_r <= 3'h0;
      end else begin
         done <= 1'b0;
         if (start && !memReq) begin
            // [RULE10] source protection on read
            memReq    <= 1'b1;
            memWrite  <= 1'b0;
            memAddr   <= srcAddr;
            memProt   <= srcProt;
            dstAddr_r <= dstAddr;
            dstProt_r <= dstProt;
         end else if (memReq && memAck && !memWrite) begin
            // [RULE10] destination protection on write
            memWrite <= 1'b1;
            memAddr  <= dstAddr_r;
            memProt  <= dstProt_r;
            memWdata <= memRdata;
            data     <= memRdata;
         end else if (memReq && memAck && memWrite) begin
            memReq   <= 1'b0;
            memWrite <= 1'b0;
            done     <= 1'b1;
         end
      end
   end

endmodule

// >>> hw/sgcs_sequencer.v
// scatter-gather cycle sequencer for one channel, with apb registers
`include "sgcs_consts.vh"
module sgcs_sequencer (
   // clock and reset
   input  wire        clock,
   input  wire        resetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // channel request and arbitration
   input  wire        dmaReq,
   input  wire        arbGrant,
   output reg         dmaActive,
   output reg         dmaDone,
   output reg         useBurst,
   // memory master port
   output wire        memReq,
   output wire        memWrite,
   output wire [31:0] memAddr,
   output wire [31:0] memWdata,
   output wire [2:0]  memProt,
   input  wire        memAck,
   input  wire [31:0] memRdata
);

   localparam ST_IDLE = 2'h0;
   localparam ST_COPY = 2'h1;
   localparam ST_ALT  = 2'h2;

   // registers
   reg [1:0]  state_r;
   reg        chanEn_r;
   reg        swReq_r;
   reg        autoReq_r;
   reg [31:0] priSrc_r;
   reg [31:0] priDst_r;
   reg [31:0] priCfg_r;
   reg [31:0] altBase_r;
   // alternate structure shadow: source end, destination end, control
   reg [31:0] altMem [0:2];
   reg        nextAlt_r;
   reg        periph_r;
   reg        lastTask_r;
   reg        xBusy_r;
   reg [1:0]  copyIdx_r;
   reg [10:0] beat_r;

   wire        reqSync;
   wire        xDone;
   wire [31:0] xData;
   reg         xStart;
   reg  [31:0] xSrc;
   reg  [31:0] xDst;
   reg  [2:0]  xSprot;
   reg  [2:0]  xDprot;

   // the request is a pin: two flops before the start logic reads it
   sgcs_sync2 u_reqSync (
      .clock  (clock),
      .resetn (resetn),
      .din    (dmaReq),
      .dout   (reqSync)
   );

   sgcs_xfer u_xfer (
      .clock    (clock),
      .resetn   (resetn),
      .start    (xStart),
      .srcAddr  (xSrc),
      .dstAddr  (xDst),
      .srcProt  (xSprot),
      .dstProt  (xDprot),
      .done     (xDone),
      .data     (xData),
      .memReq   (memReq),
      .memWrite (memWrite),
      .memAddr  (memAddr),
      .memWdata (memWdata),
      .memProt  (memProt),
      .memAck   (memAck),
      .memRdata (memRdata)
   );

   // field views
   wire [2:0]  priType  = priCfg_r[`SGCS_CC_HI:`SGCS_CC_LO];
   wire [9:0]  priNm1   = priCfg_r[`SGCS_NM1_HI:`SGCS_NM1_LO];
   wire [31:0] altCfg   = altMem[2];
   wire [2:0]  altType  = altCfg[`SGCS_CC_HI:`SGCS_CC_LO];
   wire [9:0]  altNm1   = altCfg[`SGCS_NM1_HI:`SGCS_NM1_LO];
   wire [3:0]  altRpow  = altCfg[`SGCS_RPOW_HI:`SGCS_RPOW_LO];
   wire [10:0] altBurst = 11'h001 << altRpow;
   wire [3:0]  priRpow  = priCfg_r[`SGCS_RPOW_HI:`SGCS_RPOW_LO];
   wire [10:0] priBurst = 11'h001 << priRpow;

   // a transfer ending with the counter at zero finishes the structure
   wire copyEnd  = (priNm1 == 10'h000);
   wire copyStop = copyEnd || (copyIdx_r == `SGCS_COPY_LAST) ||
                   ({9'h000, copyIdx_r} == (priBurst - 11'h001));
   wire altEnd   = (altNm1 == 10'h000);
   wire altPause = (beat_r == (altBurst - 11'h001));

   // [RULE17] task after invalidation handled as basic
   wire altBasic = (altType == `SGCS_CC_BASIC) || lastTask_r;

   // [RULE13] request line, software or auto-request
   wire anyReq   = reqSync || swReq_r || autoReq_r;
   wire startNow = (state_r == ST_IDLE) && chanEn_r && arbGrant && anyReq;

   // [RULE7] primary code selects memory or peripheral sequencing
   wire priMem   = (priType == `SGCS_CC_MEM_PRI);
   wire priPer   = (priType == `SGCS_CC_PER_PRI);
   // [RULE19] alternate codes accepted for a task
   wire altValid = (altType == `SGCS_CC_BASIC) ||
                   (altType == `SGCS_CC_MEM_ALT) ||
                   (altType == `SGCS_CC_PER_ALT);

   // apb phases: one wait state, write lands at the ready edge
   wire apbAcc   = psel && penable;
   wire apbWr    = apbAcc && pready && pwrite;
   wire addrOk   = (paddr <= `SGCS_OFF_ALT_W2) && (paddr[1:0] == 2'h0);
   wire wrCtrl   = apbWr && (paddr == `SGCS_OFF_CTRL);

   // transfer addresses: end pointer minus remaining words; copy destination is alternate base plus copy index
   always @* begin
      xStart = 1'b0;
      xSrc   = `SGCS_RST_WORD;
      xDst   = `SGCS_RST_WORD;
      xSprot = 3'h0;
      xDprot = 3'h0;

      if (state_r == ST_COPY) begin
         xStart = !xBusy_r;
         xSrc   = priSrc_r - {20'h0_0000, priNm1, 2'h0};
         xDst   = altBase_r + {28'h000_0000, copyIdx_r, 2'h0};
         xSprot = priCfg_r[`SGCS_SPROT_HI:`SGCS_SPROT_LO];
         xDprot = priCfg_r[`SGCS_DPROT_HI:`SGCS_DPROT_LO];
      end else if (state_r == ST_ALT) begin
         xStart = !xBusy_r;
         xSrc   = altMem[0] - {20'h0_0000, altNm1, 2'h0};
         xDst   = altMem[1] - {20'h0_0000, altNm1, 2'h0};
         xSprot = altCfg[`SGCS_SPROT_HI:`SGCS_SPROT_LO];
         xDprot = altCfg[`SGCS_DPROT_HI:`SGCS_DPROT_LO];
      end
   end

   // sequencer and register file
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_r    <= ST_IDLE;
         chanEn_r   <= 1'b0;
         swReq_r    <= 1'b0;
         autoReq_r  <= 1'b0;
         useBurst   <= 1'b0;

         priSrc_r   <= `SGCS_RST_WORD;
         priDst_r   <= `SGCS_RST_WORD;
         priCfg_r   <= `SGCS_RST_WORD;
         altBase_r  <= `SGCS_RST_WORD;
         altMem[0]  <= `SGCS_RST_WORD;
         altMem[1]  <= `SGCS_RST_WORD;
         altMem[2]  <= `SGCS_RST_WORD;
         nextAlt_r  <= 1'b0;
         periph_r   <= 1'b0;
         lastTask_r <= 1'b0;
         xBusy_r    <= 1'b0;
         copyIdx_r  <= 2'h0;
         beat_r     <= 11'h000;
         dmaDone    <= 1'b0;
         dmaActive  <= 1'b0;
      end else begin
         dmaDone <= 1'b0;

         // software side; the sequencer below overrides on a clash
         if (apbWr) begin
            case (paddr)
               `SGCS_OFF_CTRL: begin
                  chanEn_r <= pwdata[`SGCS_CTRL_EN];
                  useBurst <= pwdata[`SGCS_CTRL_BURST];
               end
               `SGCS_OFF_PRI_SRC:  priSrc_r  <= pwdata;
               `SGCS_OFF_PRI_DST:  priDst_r  <= pwdata;
               `SGCS_OFF_PRI_CFG:  priCfg_r  <= pwdata;
               `SGCS_OFF_ALT_BASE: altBase_r <= pwdata;
               // read-only and unmapped words drop the write
               default: ;
            endcase
         end
         // a software request written in the start cycle is kept
         if (wrCtrl && pwdata[`SGCS_CTRL_SWREQ])
            swReq_r <= 1'b1;
         else if (startNow)
            swReq_r <= 1'b0;

         if (startNow)
            autoReq_r <= 1'b0;

         // busy stops a second start while done is still in flight
         if (xStart)
            xBusy_r <= 1'b1;
         else if (xDone)
            xBusy_r <= 1'b0;

         case (state_r)
            ST_IDLE: begin
               // idle drops active; a start below raises it again
               dmaActive <= 1'b0;
               if (startNow) begin
                  beat_r <= 11'h000;
                  if (nextAlt_r) begin
                     if (altValid) begin
                        state_r   <= ST_ALT;
                        dmaActive <= 1'b1;
                     end else begin
                        // invalid alternate ends the transaction
                        chanEn_r  <= 1'b0;
                        nextAlt_r <= 1'b0;
                     end
                  end else if (priMem || priPer) begin
                     // [RULE1] primary copy opens each round
                     state_r    <= ST_COPY;
                     dmaActive  <= 1'b1;
                     periph_r   <= priPer;
                     lastTask_r <= 1'b0;
                     copyIdx_r  <= 2'h0;
                  end else begin
                     // [RULE2] invalid primary ends the transaction
                     chanEn_r <= 1'b0;
                  end
               end
            end

            ST_COPY: begin
               if (xDone) begin
                  // the fourth descriptor word has no shadow entry
                  if (copyIdx_r != `SGCS_COPY_LAST)
                     altMem[copyIdx_r] <= xData;
                  copyIdx_r <= copyIdx_r + 2'h1;
                  if (copyEnd) begin
                     // [RULE3] primary invalid after the N-th transfer
                     priCfg_r[`SGCS_CC_HI:`SGCS_CC_LO] <= `SGCS_CC_INVALID;
                     lastTask_r <= 1'b1;
                  end else begin
                     priCfg_r[`SGCS_NM1_HI:`SGCS_NM1_LO] <= priNm1 - 10'h001;
                  end
                  if (copyStop) begin
                     nextAlt_r <= 1'b1;
                     beat_r    <= 11'h000;
                     if (periph_r && altValid) begin
                        // [RULE14] straight into the task, active stays high
                        state_r <= ST_ALT;
                     end else if (periph_r) begin
                        // [RULE2] an invalid copied task ends the transaction
                        state_r   <= ST_IDLE;
                        dmaActive <= 1'b0;
                        chanEn_r  <= 1'b0;
                        nextAlt_r <= 1'b0;
                     end else begin
                        // [RULE12] auto-request after the copy
                        autoReq_r <= 1'b1;
                        state_r   <= ST_IDLE;
                        dmaActive <= 1'b0;
                     end
                  end
               end
            end

            ST_ALT: begin
               if (xDone) begin
                  beat_r <= beat_r + 11'h001;
                  if (altEnd) begin
                     // [RULE20] completed alternate becomes invalid
                     altMem[2][`SGCS_CC_HI:`SGCS_CC_LO] <= `SGCS_CC_INVALID;
                     state_r   <= ST_IDLE;
                     dmaActive <= 1'b0;
                     nextAlt_r <= 1'b0;
                     // [RULE9] burst-only set after the alternate cycle
                     if (periph_r && priCfg_r[`SGCS_NXBURST])
                        useBurst <= 1'b1;
                     if (altBasic) begin
                        // [RULE4] done only for a basic ending
                        // [RULE18] one-cycle pulse, channel stops
                        dmaDone  <= 1'b1;
                        chanEn_r <= 1'b0;
                     end else if (!periph_r) begin
                        // [RULE12] auto-request after the task
                        autoReq_r <= 1'b1;
                     end
                     // [RULE15] peripheral waits for its own request
                  end else begin
                     altMem[2][`SGCS_NM1_HI:`SGCS_NM1_LO] <= altNm1 - 10'h001;
                     if (altPause) begin
                        // arbitration point inside the task
                        state_r   <= ST_IDLE;
                        dmaActive <= 1'b0;
                        if (!periph_r)
                           autoReq_r <= 1'b1;
                     end
                  end
               end
            end

            default: begin
               state_r   <= ST_IDLE;
               dmaActive <= 1'b0;
            end
         endcase
      end
   end

   // apb answer: ready one cycle into the access phase
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pready  <= 1'b0;
         prdata  <= `SGCS_RST_WORD;
         pslverr <= 1'b0;
      end else begin
         pready  <= apbAcc && !pready;
         // pslverr rides with pready so both are seen at one edge
         pslverr <= apbAcc && !pready && !addrOk;

         if (apbAcc && !pready && !pwrite) begin
            case (paddr)
               `SGCS_OFF_CTRL:
                  prdata <= {29'h0000_0000, useBurst, swReq_r, chanEn_r};
               `SGCS_OFF_PRI_SRC:  prdata <= priSrc_r;
               `SGCS_OFF_PRI_DST:  prdata <= priDst_r;
               `SGCS_OFF_PRI_CFG:  prdata <= priCfg_r;
               `SGCS_OFF_ALT_BASE: prdata <= altBase_r;
               `SGCS_OFF_STATUS:
                  prdata <= {24'h00_0000, autoReq_r, lastTask_r, periph_r,
                             nextAlt_r, dmaActive, 1'b0, state_r};
               `SGCS_OFF_ALT_W0:   prdata <= altMem[0];
               `SGCS_OFF_ALT_W1:   prdata <= altMem[1];
               `SGCS_OFF_ALT_W2:   prdata <= altMem[2];
               default:            prdata <= `SGCS_RST_WORD;
            endcase
         end
      end
   end

endmodule

// >>> testbench/sgcs_sequencer_props.sv
// concurrent checks on the scatter-gather sequencer ports
module sgcs_sequencer_props (
   // clock and reset
   input wire logic        clock,
   input wire logic        resetn,
   // apb handshake
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   // channel
   input wire logic        arbGrant,
   input wire logic        dmaActive,
   input wire logic        dmaDone,
   // memory port
   input wire logic        memReq,
   input wire logic        memWrite,
   input wire logic [31:0] memAddr,
   input wire logic [31:0] memWdata,
   input wire logic [2:0]  memProt,
   input wire logic        memAck,
   input wire logic [31:0] memRdata
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock);
   endclocking
   default disable iff (!resetn);
   sequence rdAck;
      memReq && memAck && !memWrite;
   endsequence
   sequence wrAck;
      memReq && memAck && memWrite;
   endsequence
   apb_answer_a: assert property (psel && penable && !pready |=> pready)
      else $error("apb access not answered in its second cycle");
   apb_pulse_a: assert property (pready |=> !pready)
      else $error("apb ready held longer than one cycle");
   xfer_order_a: assert property (rdAck |=> memReq && memWrite)
      else $error("source read not followed by destination write");
   data_pair_a: assert property (rdAck |=> memWdata == $past(memRdata))
      else $error("written word differs from word read");
   wr_release_a: assert property (wrAck |=> !memReq)
      else $error("memory request kept after write ack");
   req_hold_a: assert property (memReq && !memAck |=>
      memReq && $stable({memWrite, memAddr, memProt}))
      else $error("memory request changed before ack");
   mem_active_a: assert property (memReq |-> dmaActive)
      else $error("memory request while channel inactive");
   start_grant_a: assert property ($rose(dmaActive) |-> $past(arbGrant))
      else $error("channel started without priority");
   done_pulse_a: assert property (dmaDone |=> !dmaDone)
      else $error("completion pulse longer than one cycle");
   done_quiet_a: assert property (dmaDone |-> !memReq ##1 !memReq)
      else $error("memory traffic around completion pulse");
endmodule

bind sgcs_sequencer sgcs_sequencer_props u_props (
   .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pready(pready),
   .arbGrant(arbGrant), .dmaActive(dmaActive), .dmaDone(dmaDone), .memReq(memReq),
   .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata), .memProt(memProt),
   .memAck(memAck), .memRdata(memRdata)
);

// >>> testbench/sgcs_mem_model.sv
// word memory answering the sequencer's master port
module sgcs_mem_model (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        resetn,
   // wait states on
   input  wire logic        slow,
   // memory port
   input  wire logic        memReq,
   input  wire logic        memWrite,
   input  wire logic [31:0] memAddr,
   input  wire logic [31:0] memWdata,
   output logic             memAck,
   output logic      [31:0] memRdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] mem [0:255];
   logic [1:0]  cntR;
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         memAck   <= 1'b0;
         memRdata <= 32'h0000_0000;
         cntR     <= 2'h0;
      end else begin
         memAck   <= 1'b0;
         // data toggles outside an ack so a stale word never looks valid
         memRdata <= ~memRdata;
         if (memReq && memAck && memWrite) begin
            mem[memAddr[9:2]] <= memWdata;
         end else if (memReq && !memAck) begin
            // slow mode waits 0..3 cycles, varying with the address
            if (!slow || cntR == memAddr[3:2]) begin
               memAck   <= 1'b1;
               cntR     <= 2'h0;
               memRdata <= mem[memAddr[9:2]];
            end else begin
               cntR <= cntR + 2'h1;
            end
         end
      end
   end
endmodule

// >>> testbench/sgcs_sequencer_tb_top.sv
// self-checking bench for the scatter-gather sequencer
`include "sgcs_consts.vh"
module sgcs_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [2:0] SP = 3'h5;
   localparam logic [2:0] DP = 3'h2;
   logic        clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic        dmaReq = 0, arbGrant = 1, slow = 0, actD = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, rs = 32'h0000_FD71;
   logic [31:0] prdata, memAddr, memWdata, memRdata;
   logic        pready, pslverr, dmaActive, dmaDone, useBurst, memReq, memWrite, memAck;
   logic [2:0]  memProt;
   logic [66:0] wq[$];
   logic [32:0] rq[$];
   int          error_cnt = 0, n_compared = 0, doneCnt = 0, riseCnt = 0;

   sgcs_sequencer u_sgcs_sequencer (
      .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .dmaReq(dmaReq), .arbGrant(arbGrant), .dmaActive(dmaActive), .dmaDone(dmaDone),
      .useBurst(useBurst), .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
      .memWdata(memWdata), .memProt(memProt), .memAck(memAck), .memRdata(memRdata));
   sgcs_mem_model u_sgcs_mem_model (
      .clock(clock), .resetn(resetn), .slow(slow), .memReq(memReq), .memWrite(memWrite),
      .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata));

   always #2.5 clock = ~clock;

   function logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   function logic [31:0] cw(input logic [3:0] r, input logic [9:0] n, input logic b,
                            input logic [2:0] c);
      return {8'hAA, DP, SP, r, n, b, c};
   endfunction
   task report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input string nm, input logic [66:0] e, input logic [66:0] g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task fail_out(input string nm);
      error_cnt++;
      $display("BAD %s exp event got timeout", nm);
      report_and_stop();
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clock);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1;
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) fail_out("pready");
      psel <= 0;
      penable <= 0;
   endtask
   task rd(input logic [7:0] a, input logic [32:0] e);
      rq.push_back(e);
      apb(1'b0, a, 32'h0000_0000);
   endtask
   task ew(input logic [31:0] a, input logic [31:0] d);
      wq.push_back({a, d, DP});
   endtask

   // results are taken off the queues as the design produces them
   always @(negedge clock) begin
      if (psel && penable && pready === 1'b1 && !pwrite)
         chk("rd", rq.pop_front(), {pslverr, prdata});
      if (memReq && memAck === 1'b1 && memWrite)
         chk("wr", wq.size() ? wq.pop_front() : 67'h0, {memAddr, memWdata, memProt});
      if (memReq && memAck === 1'b1 && !memWrite)
         chk("rprot", SP, memProt);
      if (dmaDone === 1'b1) doneCnt++;
      if (dmaActive === 1'b1 && !actD) riseCnt++;
      actD = (dmaActive === 1'b1);
   end

   task automatic run_sg(input logic per);
      logic [31:0] s[3];
      logic [31:0] d[8];
      logic [31:0] cp, ca, cb;
      int          k;
      // word fields, four per burst, two tasks
      cp = cw(4'h2, 10'h007, per, per ? `SGCS_CC_PER_PRI : `SGCS_CC_MEM_PRI);
      ca = cw(4'h1, 10'h001, 1'b0, per ? `SGCS_CC_PER_ALT : `SGCS_CC_MEM_ALT);
      // memory run leaves a non-basic code on the last task
      cb = cw(4'h0, 10'h000, 1'b0, per ? `SGCS_CC_BASIC : `SGCS_CC_MEM_ALT);
      foreach (s[i]) s[i] = xs();
      u_sgcs_mem_model.mem[32] = s[0];
      u_sgcs_mem_model.mem[33] = s[1];
      u_sgcs_mem_model.mem[36] = s[2];
      d = '{32'h0000_0084, 32'h0000_0304, ca, xs(), 32'h0000_0090, 32'h0000_0310, cb, xs()};
      // descriptors end at the primary source pointer
      for (k = 0; k < 8; k++) begin
         u_sgcs_mem_model.mem[64 + k] = d[k];
         ew(32'h0000_0200 + 4 * (k % 4), d[k]);
         if (k == 3) ew(32'h0000_0300, s[0]);
         if (k == 3) ew(32'h0000_0304, s[1]);
      end
      ew(32'h0000_0310, s[2]);
      apb(1'b1, `SGCS_OFF_ALT_BASE, 32'h0000_0200);
      apb(1'b1, `SGCS_OFF_PRI_SRC, 32'h0000_011C);
      apb(1'b1, `SGCS_OFF_PRI_CFG, cp);
      apb(1'b1, `SGCS_OFF_CTRL, per ? 32'h0000_0001 : 32'h0000_0003);
      if (per) begin
         dmaReq <= 1;
         for (k = 0; k < 200 && riseCnt == 0; k++) @(posedge clock);
         if (riseCnt == 0) fail_out("start");
         dmaReq <= 0;
         for (k = 0; k < 3000 && !(wq.size() == 5 && dmaActive === 1'b0); k++) @(posedge clock);
         if (wq.size() != 5 || dmaActive !== 1'b0) fail_out("task");
         arbGrant <= 0;
         dmaReq <= 1;
         repeat (20) @(posedge clock);
         chk("hold", 1, riseCnt);
         arbGrant <= 1;
      end
      for (k = 0; k < 3000 && doneCnt == 0; k++) @(posedge clock);
      if (doneCnt == 0) fail_out("done");
      dmaReq <= 0;
      repeat (10) @(posedge clock);
      chk("done", 1, doneCnt);
      chk("runs", per ? 2 : 4, riseCnt);
      chk("left", 0, wq.size());
      chk("burst", per, useBurst);
      rd(`SGCS_OFF_PRI_CFG, {1'b0, cp[31:14], 10'h000, cp[3], 3'h0});
      rd(`SGCS_OFF_ALT_W2, {1'b0, cb[31:3], 3'h0});
      rd(`SGCS_OFF_CTRL, {30'h0, per, 2'h0});
   endtask

   initial begin
      repeat (2) @(posedge clock);
      resetn <= 1;
      rd(`SGCS_OFF_CTRL, 33'h0_0000_0000);
      rd(`SGCS_OFF_STATUS, 33'h0_0000_0000);
      rd(8'h24, 33'h1_0000_0000);
      run_sg(1'b0);
      // a fresh start on the invalidated primary must end quietly
      apb(1'b1, `SGCS_OFF_CTRL, 32'h0000_0003);
      repeat (30) @(posedge clock);
      rd(`SGCS_OFF_CTRL, 33'h0_0000_0000);
      chk("stray", 1, doneCnt);
      resetn <= 0;
      repeat (2) @(posedge clock);
      resetn <= 1;
      slow <= 1;
      doneCnt = 0;
      riseCnt = 0;
      run_sg(1'b1);
      report_and_stop();
   end
endmodule
